// >>> logic/ldac_pkg.sv
// constants for the ladder reference converter control block
// assumes a 32-bit apb slave port with byte addresses
package ldac_pkg;
	localparam logic [7:0] LDAC_OFS_PRIMARY = 8'h00;
	localparam logic [7:0] LDAC_OFS_LEVEL = 8'h04;
	localparam logic [7:0] LDAC_OFS_PIN = 8'h08;
	localparam int LDAC_ADDR_W = 8;
	localparam int LDAC_LEVEL_W = 5;
	localparam int LDAC_LEVELS = 32;
	localparam int LDAC_BIT_EN = 7;
	localparam int LDAC_BIT_LPS = 6;
	localparam int LDAC_BIT_OE = 5;
	localparam int LDAC_BIT_PSS_HI = 3;
	localparam int LDAC_BIT_PSS_LO = 2;
	localparam int LDAC_BIT_NSS = 0;
	localparam logic [7:0] LDAC_PRIMARY_MASK = 8'hED;
	localparam logic [7:0] LDAC_LEVEL_MASK = 8'h1F;
	localparam logic [7:0] LDAC_PRIMARY_RST = 8'h00;
	localparam logic [4:0] LDAC_LEVEL_RST = 5'h00;
	typedef enum logic [1:0] {
		LDAC_PSRC_SUPPLY,
		LDAC_PSRC_VREF_PIN,
		LDAC_PSRC_FIXED_REF,
		LDAC_PSRC_RESERVED
	} ldac_psrc_t;
endpackage

// >>> logic/ldac_ctrl.sv
// ladder reference converter control: registers, source decode, pin override
// assumes apb master on pclk; analog ladder driven by the select outputs
//
// Behaviour
// - converter runs only while the enable bit is set
// - five bit level code gives 32 levels
// - output is negative source plus span times code over 32
// - pin drive enable routes the level to the output pin
// - routing overrides the pin digital driver and input detector
// - digital read of the pin returns zero while routed
// - while disabled, low-power bit set drops negative end, clear drops positive end
// - wake from sleep leaves the first control register untouched
// - reset disables, unroutes the pin and clears the level code
// - positive source field: supply, external pin, fixed reference, reserved
// - negative source bit picks external pin or ground
// - unimplemented bits read as zero
// - level code sits right-justified in the low five bits
// - outside reset, level feeds comparator and adc channel, and feeds the output pin only while routed
`timescale 1ns/1ns
module ldac_ctrl
	import ldac_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pin_in,
	output logic converter_active,
	output logic [LDAC_LEVEL_W-1:0] level_code,
	output logic pos_end_connected,
	output logic neg_end_connected,
	output logic src_pos_supply,
	output logic src_pos_vref_pin,
	output logic src_pos_fixed_ref,
	output logic src_neg_vref_pin,
	output logic level_to_comparator,
	output logic level_to_adc,
	output logic reference_out_pin_en,
	output logic pin_digital_override
);
	logic [7:0] primary_q, primary_d;
	logic [LDAC_LEVEL_W-1:0] level_q, level_d;
	logic [31:0] prdata_q, prdata_d;
	logic pslverr_q, pslverr_d;
	logic pready_q, pready_d;
	logic pin_s1_q, pin_s2_q;
	logic [LDAC_ADDR_W-1:0] addr;
	logic hit_primary, hit_level, hit_pin, mapped, wr_acc, rd_acc;

	assign addr = paddr[LDAC_ADDR_W-1:0];
	assign hit_primary = paddr[31:LDAC_ADDR_W] == '0 && addr == LDAC_OFS_PRIMARY;
	assign hit_level = paddr[31:LDAC_ADDR_W] == '0 && addr == LDAC_OFS_LEVEL;
	assign hit_pin = paddr[31:LDAC_ADDR_W] == '0 && addr == LDAC_OFS_PIN;
	assign mapped = hit_primary | hit_level | hit_pin;
	// zero wait states: access phase always completes in its first cycle
	assign wr_acc = psel & penable & pready_q & pwrite;
	assign rd_acc = psel & penable & pready_q & ~pwrite;

	always_comb begin
		primary_d = primary_q;
		level_d = level_q;
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		pready_d = 1'b0;
		if (psel & ~penable) begin
			pslverr_d = ~mapped;
			pready_d = 1'b1;
		end
		if (wr_acc & hit_primary & pstrb[0]) begin
			primary_d = pwdata[7:0] & LDAC_PRIMARY_MASK;
		end
		if (wr_acc & hit_level & pstrb[0]) begin
			level_d = pwdata[LDAC_LEVEL_W-1:0];
		end
		if (psel & ~penable & ~pwrite) begin
			prdata_d = '0;
			if (hit_primary) begin
				prdata_d = {24'h00_0000, primary_q};
			end else if (hit_level) begin
				prdata_d = {27'h000_0000, level_q};
			end else if (hit_pin) begin
				// routed pin always reads low
				prdata_d = {31'h0000_0000, pin_s2_q & ~primary_q[LDAC_BIT_OE]};
			end
		end
	end

	// no sleep input: wake leaves the primary register as it was
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_q <= LDAC_PRIMARY_RST;
			level_q <= LDAC_LEVEL_RST;
			prdata_q <= '0;
			pslverr_q <= 1'b0;
			pready_q <= 1'b0;
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else begin
			primary_q <= primary_d;
			level_q <= level_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
			pready_q <= pready_d;
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	ldac_psrc_t psrc;
	logic active_d, pos_d, neg_d, sp_sup_d, sp_vref_d, sp_fix_d, sn_d, oe_d;
	assign psrc = ldac_psrc_t'(primary_q[LDAC_BIT_PSS_HI:LDAC_BIT_PSS_LO]);

	always_comb begin
		active_d = primary_q[LDAC_BIT_EN];
		// when disabled one ladder end is opened for least current
		pos_d = primary_q[LDAC_BIT_EN] | primary_q[LDAC_BIT_LPS];
		neg_d = primary_q[LDAC_BIT_EN] | ~primary_q[LDAC_BIT_LPS];
		sp_sup_d = 1'b0;
		sp_vref_d = 1'b0;
		sp_fix_d = 1'b0;
		case (psrc)
			LDAC_PSRC_SUPPLY: sp_sup_d = 1'b1;
			LDAC_PSRC_VREF_PIN: sp_vref_d = 1'b1;
			LDAC_PSRC_FIXED_REF: sp_fix_d = 1'b1;
			default: sp_sup_d = 1'b0; // reserved code connects nothing
		endcase
		sn_d = primary_q[LDAC_BIT_NSS];
		oe_d = primary_q[LDAC_BIT_OE];
	end

	// analog ladder forms vneg + (vpos - vneg) * code / 32 from these selects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_active <= 1'b0;
			level_code <= '0;
			pos_end_connected <= 1'b0;
			neg_end_connected <= 1'b1;
			src_pos_supply <= 1'b1;
			src_pos_vref_pin <= 1'b0;
			src_pos_fixed_ref <= 1'b0;
			src_neg_vref_pin <= 1'b0;
			level_to_comparator <= 1'b0;
			level_to_adc <= 1'b0;
			reference_out_pin_en <= 1'b0;
			pin_digital_override <= 1'b0;
		end else begin
			converter_active <= active_d;
			level_code <= level_q;
			pos_end_connected <= pos_d;
			neg_end_connected <= neg_d;
			src_pos_supply <= sp_sup_d;
			src_pos_vref_pin <= sp_vref_d;
			src_pos_fixed_ref <= sp_fix_d;
			src_neg_vref_pin <= sn_d;
			level_to_comparator <= 1'b1;
			level_to_adc <= 1'b1;
			reference_out_pin_en <= oe_d;
			pin_digital_override <= oe_d;
		end
	end

	assign prdata = prdata_q;
	// ready comes from a flop: high for the one access cycle, so no wait state is added
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// bus answer
	property p_ready;
		@(posedge pclk) disable iff (!presetn)
		psel & ~penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("setup not answered");

	property p_ready_idle;
		@(posedge pclk) disable iff (!presetn)
		!psel |=> !pready;
	endproperty
	a_ready_idle: assert property (p_ready_idle) else $error("ready outside a transfer");

	property p_slverr;
		@(posedge pclk) disable iff (!presetn)
		psel & ~penable & ~mapped |=> pslverr;
	endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");

	// stored register contents
	property p_enable;
		@(posedge pclk) disable iff (!presetn)
		wr_acc & hit_primary & pstrb[0] |-> ##2 converter_active == $past(pwdata[LDAC_BIT_EN], 2);
	endproperty
	a_enable: assert property (p_enable) else $error("enable not applied");

	property p_level;
		@(posedge pclk) disable iff (!presetn)
		wr_acc & hit_level & pstrb[0] |-> ##2 level_code == $past(pwdata[LDAC_LEVEL_W-1:0], 2);
	endproperty
	a_level: assert property (p_level) else $error("level code not applied");

	property p_primary_unimpl;
		@(posedge pclk) disable iff (!presetn)
		(primary_q & ~LDAC_PRIMARY_MASK) == '0;
	endproperty
	a_primary_unimpl: assert property (p_primary_unimpl) else $error("spare bit stored");

	// outside reset only a bus write moves the control registers; no sleep or wake event touches them
	property p_primary_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr_acc & hit_primary & pstrb[0]) |=> $stable(primary_q);
	endproperty
	a_primary_hold: assert property (p_primary_hold) else $error("primary changed alone");

	property p_level_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr_acc & hit_level & pstrb[0]) |=> $stable(level_q);
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level changed alone");

	property p_reset_state;
		@(posedge pclk)
		$rose(presetn) |-> !converter_active && level_code == '0 && !reference_out_pin_en;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

	// ladder controls follow the registers one edge later
	property p_active;
		@(posedge pclk) disable iff (!presetn)
		converter_active == $past(primary_q[LDAC_BIT_EN]);
	endproperty
	a_active: assert property (p_active) else $error("enable output wrong");

	property p_route;
		@(posedge pclk) disable iff (!presetn)
		reference_out_pin_en == $past(primary_q[LDAC_BIT_OE]);
	endproperty
	a_route: assert property (p_route) else $error("pin routing wrong");

	property p_oe;
		@(posedge pclk) disable iff (!presetn)
		pin_digital_override == $past(primary_q[LDAC_BIT_OE]);
	endproperty
	a_oe: assert property (p_oe) else $error("override differs from routing");

	property p_ends_on;
		@(posedge pclk) disable iff (!presetn)
		converter_active |-> pos_end_connected && neg_end_connected;
	endproperty
	a_ends_on: assert property (p_ends_on) else $error("enabled ladder end open");

	property p_lps;
		@(posedge pclk) disable iff (!presetn)
		!converter_active |-> pos_end_connected != neg_end_connected;
	endproperty
	a_lps: assert property (p_lps) else $error("low power end wrong");

	property p_lps_side;
		@(posedge pclk) disable iff (!presetn)
		!converter_active |-> pos_end_connected == $past(primary_q[LDAC_BIT_LPS]);
	endproperty
	a_lps_side: assert property (p_lps_side) else $error("low power side wrong");

	property p_src;
		@(posedge pclk) disable iff (!presetn)
		$onehot0({src_pos_supply, src_pos_vref_pin, src_pos_fixed_ref});
	endproperty
	a_src: assert property (p_src) else $error("two positive sources");

	property p_psrc_decode;
		@(posedge pclk) disable iff (!presetn)
		{src_pos_fixed_ref, src_pos_vref_pin, src_pos_supply} ==
			{$past(psrc) == LDAC_PSRC_FIXED_REF, $past(psrc) == LDAC_PSRC_VREF_PIN,
			$past(psrc) == LDAC_PSRC_SUPPLY};
	endproperty
	a_psrc_decode: assert property (p_psrc_decode) else $error("positive source decode wrong");

	property p_nss;
		@(posedge pclk) disable iff (!presetn)
		src_neg_vref_pin == $past(primary_q[LDAC_BIT_NSS]);
	endproperty
	a_nss: assert property (p_nss) else $error("negative source mismatch");

	property p_level_out;
		@(posedge pclk) disable iff (!presetn)
		level_code == $past(level_q);
	endproperty
	a_level_out: assert property (p_level_out) else $error("level output stale");

	property p_feed;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> level_to_comparator && level_to_adc;
	endproperty
	a_feed: assert property (p_feed) else $error("level not fed to consumers");

	// reads
	property p_pinread;
		@(posedge pclk) disable iff (!presetn)
		rd_acc & hit_pin & primary_q[LDAC_BIT_OE] & $stable(primary_q) |-> prdata == '0;
	endproperty
	a_pinread: assert property (p_pinread) else $error("routed pin read nonzero");

	property p_unimpl;
		@(posedge pclk) disable iff (!presetn)
		rd_acc & hit_level |-> prdata[31:LDAC_LEVEL_W] == '0;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bits set");

	c_write: cover property (@(posedge pclk) wr_acc & hit_primary);
	c_route: cover property (@(posedge pclk) reference_out_pin_en);
	c_clamp: cover property (@(posedge pclk) !converter_active && level_code == 5'h1F);
	c_clamp_low: cover property (@(posedge pclk) !converter_active && !pos_end_connected);
	c_unmapped: cover property (@(posedge pclk) pslverr);
endmodule // ldac_ctrl

// >>> test/ldac_analog_model.sv
// behavioural ladder and pin beyond the control block
// assumes the select outputs of ldac_ctrl; voltages in millivolts
`timescale 1ns/1ns
module ldac_analog_model
	import ldac_pkg::*;
(
	input wire logic pclk,
	input wire logic src_pos_supply,
	input wire logic src_pos_vref_pin,
	input wire logic src_pos_fixed_ref,
	input wire logic src_neg_vref_pin,
	input wire logic pos_end_connected,
	input wire logic neg_end_connected,
	input wire logic [LDAC_LEVEL_W-1:0] level_code,
	output logic pin_in,
	output int vout_mv
);
	int pos_mv;
	int neg_mv;
	initial pin_in = 1'b0;
	// outside pull-up holds the pad high, so a masked read differs from a real one
	always @(posedge pclk) pin_in <= 1'b1;
	always_comb begin
		pos_mv = src_pos_supply ? 3300 : src_pos_vref_pin ? 2000 : src_pos_fixed_ref ? 1024 : 0;
		neg_mv = src_neg_vref_pin ? 500 : 0;
		vout_mv = neg_mv + (pos_mv - neg_mv) * int'(level_code) / LDAC_LEVELS;
		if (!neg_end_connected) vout_mv = pos_mv;
		if (!pos_end_connected) vout_mv = neg_mv;
	end
endmodule // ldac_analog_model

// >>> test/ladder_dac_control_tb.sv
// register and output checks of ldac_ctrl over apb
// assumes a single pclk domain and the analog model beside it
`timescale 1ns/1ns
`define CHK(n, x, s) begin samples_checked++; if ((s) !== (x)) begin fails++; \
	$display("unexpected %s exp %0h got %0h", n, x, s); end end
module ladder_dac_control_tb;
	import ldac_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, r;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, pin_in, converter_active, pos_end_connected, neg_end_connected, e;
	logic src_pos_supply, src_pos_vref_pin, src_pos_fixed_ref, src_neg_vref_pin;
	logic level_to_comparator, level_to_adc, reference_out_pin_en, pin_digital_override;
	logic [LDAC_LEVEL_W-1:0] level_code;
	int vout_mv, fails = 0, samples_checked = 0, k;
	always #5 pclk = ~pclk;
	ldac_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .pin_in, .converter_active, .level_code,
		.pos_end_connected, .neg_end_connected, .src_pos_supply, .src_pos_vref_pin,
		.src_pos_fixed_ref, .src_neg_vref_pin, .level_to_comparator, .level_to_adc,
		.reference_out_pin_en, .pin_digital_override);
	ldac_analog_model i_far (.pclk, .src_pos_supply, .src_pos_vref_pin, .src_pos_fixed_ref,
		.src_neg_vref_pin, .pos_end_connected, .neg_end_connected, .level_code, .pin_in,
		.vout_mv);
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// outputs follow one edge after the access edge
		@(posedge pclk);
		@(negedge pclk);
	endtask
	task results;
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		#20000;
		fails++;
		results;
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (k = 0; k < 2; k++) begin
			@(negedge pclk);
			`CHK("act", 1'b0, converter_active)
			`CHK("pin", 1'b0, reference_out_pin_en)
			`CHK("lvl", 5'h00, level_code)
			apb(1'b0, LDAC_OFS_LEVEL, 0);
			`CHK("lvlreg", 32'h0, r)
			apb(1'b1, LDAC_OFS_PRIMARY, 32'hFF);
			apb(1'b1, LDAC_OFS_LEVEL, 32'hFF);
			`CHK("act", 1'b1, converter_active)
			`CHK("pin", 2'b11, {reference_out_pin_en, pin_digital_override})
			`CHK("ends", 2'b11, {pos_end_connected, neg_end_connected})
			`CHK("feed", 2'b11, {level_to_comparator, level_to_adc})
			`CHK("lvl", 5'h1F, level_code)
			apb(1'b0, LDAC_OFS_PRIMARY, 0);
			`CHK("prim", 32'hED, r)
			apb(1'b0, LDAC_OFS_LEVEL, 0);
			`CHK("lvlreg", 32'h1F, r)
			apb(1'b0, LDAC_OFS_PIN, 0);
			`CHK("pinrd", 32'h0, r)
			apb(1'b0, 32'h10, 0);
			`CHK("unmap", 33'h1_0000_0000, {e, r})
			@(posedge pclk);
			presetn <= 1'b0;
			repeat (2) @(posedge pclk);
			presetn <= 1'b1;
		end
		for (k = 0; k < 4; k++) begin
			apb(1'b1, LDAC_OFS_PRIMARY, 32'(k * 4 + 1));
			`CHK("psrc", (k == 3) ? 3'b000 : 3'b001 << k,
				{src_pos_fixed_ref, src_pos_vref_pin, src_pos_supply})
			`CHK("nsrc", 1'b1, src_neg_vref_pin)
		end
		// a write with byte lane 0 off must not land
		@(posedge pclk);
		pstrb <= 4'h0;
		apb(1'b1, LDAC_OFS_PRIMARY, 32'hA1);
		@(posedge pclk);
		pstrb <= 4'hF;
		apb(1'b0, LDAC_OFS_PRIMARY, 0);
		`CHK("strb", 32'h0D, r)
		apb(1'b0, LDAC_OFS_PIN, 0);
		`CHK("pinrd", 32'h1, r)
		apb(1'b1, LDAC_OFS_PRIMARY, 32'h81);
		apb(1'b1, LDAC_OFS_LEVEL, 32'h10);
		`CHK("vout", 1900, vout_mv)
		apb(1'b1, LDAC_OFS_PRIMARY, 32'h48);
		apb(1'b1, LDAC_OFS_LEVEL, 32'h1F);
		`CHK("ends", 3'b010, {converter_active, pos_end_connected, neg_end_connected})
		`CHK("vout", 1024, vout_mv)
		apb(1'b1, LDAC_OFS_PRIMARY, 32'h01);
		apb(1'b1, LDAC_OFS_LEVEL, 32'h00);
		`CHK("ends", 2'b01, {pos_end_connected, neg_end_connected})
		`CHK("vout", 500, vout_mv)
		`CHK("act", 1'b0, converter_active)
		results;
	end
endmodule // ladder_dac_control_tb
